// *** pkg/wdt_pkg.sv ***
package wdt_pkg;

  // ----------------------------------------------------------------------
  // Register addresses on the CPU data space
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_CLK_SEL = 16'hff42;
  localparam logic [15:0] ADDR_WD_MODE = 16'hfff9;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          RUN_BIT      = 7;
  localparam int          MODE_HI_BIT  = 4;
  localparam int          MODE_LO_BIT  = 3;
  localparam int          CNT_SEL_LSB  = 0;
  localparam int          BUZ_SEL_LSB  = 5;
  localparam logic [7:0]  WD_MODE_RST  = 8'h00;
  localparam logic [7:0]  CLK_SEL_RST  = 8'h00;

  // ----------------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------------
  localparam int          PRE_W        = 11;
  localparam int          CNT_W        = 8;
  localparam logic [3:0]  DIV_EXP_MIN  = 4'h3;
  localparam logic [3:0]  DIV_EXP_TOP  = 4'hb;
  localparam logic [2:0]  SEL_TOP      = 3'h7;

endpackage

// *** logic/watchdog_interval_timer.sv ***
`timescale 1ns/10ps
module watchdog_interval_timer
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // CPU data space access
  input  wire logic [15:0] busAddr,
  input  wire logic        busWrEn,
  input  wire logic [7:0]  busWrData,
  input  wire logic        busRdEn,
  output logic      [7:0]  busRdData,
  // System state from the clock and standby controller
  input  wire logic        oscModeBit,
  input  wire logic        haltMode,
  input  wire logic        stopMode,
  // Interrupt controller side
  input  wire logic        timerIrqFlag,
  input  wire logic        timerIrqMask,
  input  wire logic        timerIrqPriority,
  output logic             intervalOverflowIrq,
  output logic             intervalIrqReq,
  output logic             intervalIrqPrioLow,
  output logic             nmiReq,
  output logic             sysResetReq,
  // Buzzer selection handed to the buzzer block
  output logic      [2:0]  buzzerSel
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [wdt_pkg::PRE_W-1:0] pre;
    logic [wdt_pkg::CNT_W-1:0] cnt;
    logic                      run;
    logic                      modeHi;
    logic                      modeLo;
    logic [2:0]                cntSel;
    logic [2:0]                buzSel;
    logic                      fxxPhase;
    logic                      ovfIrq;
    logic                      nmi;
    logic                      sysRst;
    logic                      irqReq;
    logic                      irqPrioLow;
    logic [7:0]                rdData;
  } wdt_state_s;

  wdt_state_s st_r;
  wdt_state_s st_nxt;

  // Divider exponent of the count clock against fxx
  function automatic logic [3:0] div_exp(input logic [2:0] sel);
    logic [3:0] e;
    e = wdt_pkg::DIV_EXP_MIN + {1'b0, sel};
    if (sel == wdt_pkg::SEL_TOP)
    begin
      e = wdt_pkg::DIV_EXP_TOP;
    end
    return e;
  endfunction

  // ----------------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------------
  logic                      fxxTick;
  logic                      cntTick;
  logic                      modeWr;
  logic                      selWr;
  logic                      runWr;
  logic                      ovf;
  logic [wdt_pkg::PRE_W-1:0] lowMask;
  logic                      modeHiSet;

  // Decode strobes and count clock; mask covers prescaler bits below the tap
  always_comb
  begin
    modeWr    = busWrEn && (busAddr == wdt_pkg::ADDR_WD_MODE);
    selWr     = busWrEn && (busAddr == wdt_pkg::ADDR_CLK_SEL);
    runWr     = modeWr && busWrData[wdt_pkg::RUN_BIT];
    // fxx is fx when the oscillator mode bit is 1, otherwise fx/2
    fxxTick   = oscModeBit || st_r.fxxPhase;
    lowMask   = wdt_pkg::PRE_W'((12'h001 << div_exp(st_r.cntSel)) - 12'h001);
    cntTick   = fxxTick && ((st_r.pre & lowMask) == lowMask) && !stopMode;
    // A clearing run write wins over a coincident overflow
    ovf       = st_r.run && cntTick && (&st_r.cnt) && !runWr;
    modeHiSet = modeWr && busWrData[wdt_pkg::MODE_HI_BIT] && !st_r.modeHi;
  end

  // Next state of the whole block
  always_comb
  begin
    st_nxt = st_r;
    // Free running divider, untouched by run writes; it halts in STOP only
    if (!stopMode)
    begin
      st_nxt.fxxPhase = !st_r.fxxPhase;
      if (fxxTick)
      begin
        st_nxt.pre = st_r.pre + wdt_pkg::PRE_W'(1);
      end
    end
    // Counter: cleared by run write, counts only while running
    if (runWr)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.run && cntTick)
    begin
      st_nxt.cnt = st_r.cnt + wdt_pkg::CNT_W'(1);
    end
    // Mode register bits only ever set by software
    if (modeWr)
    begin
      st_nxt.run    = st_r.run    | busWrData[wdt_pkg::RUN_BIT];
      st_nxt.modeHi = st_r.modeHi | busWrData[wdt_pkg::MODE_HI_BIT];
      st_nxt.modeLo = st_r.modeLo | busWrData[wdt_pkg::MODE_LO_BIT];
    end
    // Clock select register; software must stop the timer before rewriting
    if (selWr)
    begin
      st_nxt.cntSel = busWrData[wdt_pkg::CNT_SEL_LSB +: 3];
      st_nxt.buzSel = busWrData[wdt_pkg::BUZ_SEL_LSB +: 3];
    end
    // Overflow actions by mode; exactly one fires
    st_nxt.ovfIrq = ovf && !st_r.modeHi;
    st_nxt.nmi    = (ovf && st_r.modeHi && !st_r.modeLo)
                    || (modeHiSet && timerIrqFlag);
    st_nxt.sysRst = ovf && st_r.modeHi && st_r.modeLo;
    // Maskable request gated by the mask; only valid in interval mode
    st_nxt.irqReq     = timerIrqFlag && !timerIrqMask && !st_r.modeHi;
    st_nxt.irqPrioLow = timerIrqPriority;
    // Read data; reserved bits read zero, unmapped reads zero
    st_nxt.rdData = 8'h00;
    if (busRdEn && (busAddr == wdt_pkg::ADDR_WD_MODE))
    begin
      st_nxt.rdData[wdt_pkg::RUN_BIT]     = st_r.run;
      st_nxt.rdData[wdt_pkg::MODE_HI_BIT] = st_r.modeHi;
      st_nxt.rdData[wdt_pkg::MODE_LO_BIT] = st_r.modeLo;
    end
    else if (busRdEn && (busAddr == wdt_pkg::ADDR_CLK_SEL))
    begin
      st_nxt.rdData[wdt_pkg::CNT_SEL_LSB +: 3] = st_r.cntSel;
      st_nxt.rdData[wdt_pkg::BUZ_SEL_LSB +: 3] = st_r.buzSel;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset clears both registers: counting stopped, interval mode, fastest clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r            <= '0;
      st_r.run        <= wdt_pkg::WD_MODE_RST[wdt_pkg::RUN_BIT];
      st_r.modeHi     <= wdt_pkg::WD_MODE_RST[wdt_pkg::MODE_HI_BIT];
      st_r.modeLo     <= wdt_pkg::WD_MODE_RST[wdt_pkg::MODE_LO_BIT];
      st_r.cntSel     <= wdt_pkg::CLK_SEL_RST[wdt_pkg::CNT_SEL_LSB +: 3];
      st_r.buzSel     <= wdt_pkg::CLK_SEL_RST[wdt_pkg::BUZ_SEL_LSB +: 3];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // All outputs come straight from flip-flops
  assign busRdData           = st_r.rdData;
  assign intervalOverflowIrq = st_r.ovfIrq;
  assign intervalIrqReq      = st_r.irqReq;
  assign intervalIrqPrioLow  = st_r.irqPrioLow;
  assign nmiReq              = st_r.nmi;
  assign sysResetReq         = st_r.sysRst;
  assign buzzerSel           = st_r.buzSel;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // HALT has no effect on counting; the input is kept for the check below
  logic haltSeen;
  assign haltSeen = haltMode && !stopMode;

  chk_one_action: assert property (@(posedge clk) disable iff (!rst_n)
    !(intervalOverflowIrq && (nmiReq || sysResetReq)) && !(nmiReq && sysResetReq))
    else $error("more than one overflow action at once");

  chk_interval_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (ovf && !st_r.modeHi) |=> intervalOverflowIrq && !nmiReq)
    else $error("interval overflow did not raise maskable request");

  chk_nmi_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    (ovf && st_r.modeHi && !st_r.modeLo) |=> nmiReq && !intervalOverflowIrq)
    else $error("watchdog mode 1 overflow missed non-maskable request");

  chk_reset_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    (ovf && st_r.modeHi && st_r.modeLo) |=> sysResetReq && !nmiReq)
    else $error("watchdog mode 2 overflow missed system reset");

  chk_tick_tap: assert property (@(posedge clk) disable iff (!rst_n)
    (cntTick && st_r.cntSel == 3'h0) |-> (st_r.pre[2:0] == 3'h7))
    else $error("count clock not on prescaler tap");

  chk_run_clear: assert property (@(posedge clk) disable iff (!rst_n)
    runWr |=> (st_r.cnt == 8'h00) && st_r.run)
    else $error("run write did not clear and start counter");

  chk_stopped_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_r.run && !runWr) |=> $stable(st_r.cnt) && !intervalOverflowIrq)
    else $error("counter moved while run is 0");

  chk_run_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.run |=> st_r.run)
    else $error("run bit cleared without reset");

  chk_mode_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.modeHi || st_r.modeLo) |=> ($past(st_r.modeHi) -> st_r.modeHi)
      && ($past(st_r.modeLo) -> st_r.modeLo))
    else $error("mode bit cleared without reset");

  chk_early_nmi: assert property (@(posedge clk) disable iff (!rst_n)
    (modeHiSet && timerIrqFlag) |=> nmiReq)
    else $error("pending flag at watchdog entry gave no non-maskable request");

  chk_stop_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    (stopMode && !runWr) |=> $stable(st_r.cnt))
    else $error("counter moved in STOP");

  chk_halt_counts: assert property (@(posedge clk) disable iff (!rst_n)
    (haltSeen && st_r.run && cntTick && !runWr && !(&st_r.cnt))
      |=> st_r.cnt == $past(st_r.cnt) + 8'h01)
    else $error("counter stalled in HALT");

  chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    intervalIrqReq |-> ($past(timerIrqFlag) && !$past(timerIrqMask)))
    else $error("maskable request passed a set mask");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(busRdEn && busAddr == wdt_pkg::ADDR_WD_MODE) |-> (busRdData & 8'h67) == 8'h00)
    else $error("reserved mode register bits read nonzero");

  // ----------------------------------------------------------------------
  // Checks on reset values, pulses and the free divider
  // ----------------------------------------------------------------------
  // Reset is synchronous, so both registers hold zero one edge later
  chk_reset_load: assert property (@(posedge clk)
    !rst_n |=> !st_r.run && !st_r.modeHi && !st_r.modeLo && (st_r.cntSel == 3'h0)
      && (buzzerSel == 3'h0))
    else $error("reset did not clear the control registers");

  // A run write wins over a coincident overflow, so no overflow action may follow it
  chk_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (runWr && !modeHiSet) |=> !(intervalOverflowIrq || nmiReq || sysResetReq))
    else $error("overflow action followed a clearing run write");

  // The divider keeps its phase across a run write; hence the short first period
  chk_pre_free: assert property (@(posedge clk) disable iff (!rst_n)
    (runWr && fxxTick && !stopMode) |=> st_r.pre == $past(st_r.pre) + wdt_pkg::PRE_W'(1))
    else $error("run write disturbed the prescaler");

  // Interval and reset requests are single-cycle pulses
  chk_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    (intervalOverflowIrq || sysResetReq) |=> !(intervalOverflowIrq || sysResetReq))
    else $error("overflow pulse held longer than one cycle");

  // Priority is a registered copy; the first edge after reset still shows zero
  chk_prio_copy: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> (intervalIrqPrioLow == $past(timerIrqPriority)))
    else $error("priority flag not passed to the request");

  // Every select code divides fxx by at least eight
  chk_tick_floor: assert property (@(posedge clk) disable iff (!rst_n)
    cntTick |-> (st_r.pre[2:0] == 3'h7))
    else $error("count clock off the low prescaler tap");

  // Watchdog modes never raise the maskable interval pulse
  chk_wd_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.modeHi |=> !intervalOverflowIrq)
    else $error("maskable overflow pulse in watchdog mode");

endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] busAddr = 16'h0000;
  logic        busWrEn = 1'b0;
  logic [7:0]  busWrData = 8'h00;
  logic        busRdEn = 1'b0;
  logic [7:0]  busRdData;
  logic        oscModeBit = 1'b1;
  logic        haltMode = 1'b0;
  logic        stopMode = 1'b0;
  logic        timerIrqFlag = 1'b0;
  logic        timerIrqMask = 1'b0;
  logic        timerIrqPriority = 1'b0;
  logic        intervalOverflowIrq;
  logic        intervalIrqReq;
  logic        intervalIrqPrioLow;
  logic        nmiReq;
  logic        sysResetReq;
  logic [2:0]  buzzerSel;
  logic [2:0]  seen;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n;
  int          p;
  // Register rows {addr, write data, read back}; bits 4:3 of select read 0
  localparam logic [31:0] REG_ROWS [4] = '{32'hff42_ff_e7, 32'h1234_ff_00,
                                           32'hfff9_67_00, 32'hff42_e0_e0};
  // Period rows {select, osc mode, halt, period in clk cycles}
  localparam logic [31:0] PER_ROWS [3] = '{{3'h0, 1'b1, 1'b0, 27'd2048},
                                           {3'h1, 1'b0, 1'b1, 27'd8192},
                                           {3'h3, 1'b1, 1'b0, 27'd16384}};

  watchdog_interval_timer DUT (.clk(clk), .rst_n(rst_n), .busAddr(busAddr),
    .busWrEn(busWrEn), .busWrData(busWrData), .busRdEn(busRdEn), .busRdData(busRdData),
    .oscModeBit(oscModeBit), .haltMode(haltMode), .stopMode(stopMode),
    .timerIrqFlag(timerIrqFlag), .timerIrqMask(timerIrqMask),
    .timerIrqPriority(timerIrqPriority), .intervalOverflowIrq(intervalOverflowIrq),
    .intervalIrqReq(intervalIrqReq), .intervalIrqPrioLow(intervalIrqPrioLow),
    .nmiReq(nmiReq), .sysResetReq(sysResetReq), .buzzerSel(buzzerSel));

  // 250 MHz system clock
  initial
  begin
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // Reset is held ten cycles; outputs are checked quiet once, at its end
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("outputs in reset", {intervalOverflowIrq, nmiReq, sysResetReq, busRdData}, 0);
    rst_n <= 1'b1;
  endtask

  // Request held for exactly the sampled edge, released after it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge clk);
    busWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge clk);
    busRdEn <= 1'b0;
    #1;
    chk("read data", busRdData, exp);
  endtask

  // Bounded wait for any overflow pulse; cycles counted from the call
  task automatic watch(input int maxc, input bit must, output int cnt, output logic [2:0] s);
    cnt = 0;
    s = 3'h0;
    while (cnt < maxc && s === 3'h0)
    begin
      @(posedge clk);
      #1;
      cnt++;
      s = {sysResetReq, nmiReq, intervalOverflowIrq};
    end
    if (must && s === 3'h0)
    begin
      chk("overflow wait", 32'h0, 32'h1);
      test_done();
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    do_reset();
    rd(wdt_pkg::ADDR_CLK_SEL, 8'h00);
    rd(wdt_pkg::ADDR_WD_MODE, 8'h00);
    // Register rows: write then read back, unmapped address included
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_ROWS[i][31:16], REG_ROWS[i][15:8]);
      rd(REG_ROWS[i][31:16], REG_ROWS[i][7:0]);
    end
    chk("buzzer select", buzzerSel, 3'h7);
    // Interval periods; the prescaler is not cleared, so the first may be early
    for (int i = 0; i < 3; i++)
    begin
      do_reset();
      p = int'(PER_ROWS[i][26:0]);
      oscModeBit <= PER_ROWS[i][28];
      haltMode <= PER_ROWS[i][27];
      wr(wdt_pkg::ADDR_CLK_SEL, {5'h00, PER_ROWS[i][31:29]});
      wr(wdt_pkg::ADDR_WD_MODE, 8'h80);
      watch(p + 10, 1'b1, n, seen);
      chk("first period window", n >= p - p / 256 - 1 && n <= p + 2, 1);
      chk("interval pulse kind", seen, 3'b001);
      watch(p + 10, 1'b1, n, seen);
      chk("steady period", n, p);
    end
    // Select 0 after reset, oscillator mode still 1; run stays set after writing 0
    do_reset();
    p = int'(PER_ROWS[0][26:0]);
    wr(wdt_pkg::ADDR_WD_MODE, 8'h80);
    wr(wdt_pkg::ADDR_WD_MODE, 8'h00);
    rd(wdt_pkg::ADDR_WD_MODE, 8'h80);
    watch(p + 10, 1'b1, n, seen);
    watch(1000, 1'b0, n, seen);
    chk("no early overflow", seen, 3'h0);
    // Software clears the count before STOP; STOP then freezes it 499 cycles
    wr(wdt_pkg::ADDR_WD_MODE, 8'h80);
    stopMode <= 1'b1;
    repeat (499) @(posedge clk);
    stopMode <= 1'b0;
    watch(p + 600, 1'b1, n, seen);
    chk("period across stop", n >= p - p / 256 - 1 && n <= p + 2, 1);
    // Maskable request path, then mode-high set while the flag is up
    do_reset();
    timerIrqFlag <= 1'b1;
    timerIrqPriority <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("request unmasked", {intervalIrqReq, intervalIrqPrioLow}, 2'b11);
    timerIrqMask <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("request masked", intervalIrqReq, 1'b0);
    timerIrqMask <= 1'b0;
    wr(wdt_pkg::ADDR_WD_MODE, 8'h10);
    #1;
    chk("nmi on flagged mode set", nmiReq, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk("no maskable in watchdog", intervalIrqReq, 1'b0);
    // Watchdog mode 1: kicks hold off the overflow, sticky mode bits
    do_reset();
    timerIrqFlag <= 1'b0;
    wr(wdt_pkg::ADDR_WD_MODE, 8'h90);
    wr(wdt_pkg::ADDR_WD_MODE, 8'h00);
    rd(wdt_pkg::ADDR_WD_MODE, 8'h90);
    repeat (3)
    begin
      watch(1500, 1'b0, n, seen);
      chk("kicked no overflow", seen, 3'h0);
      wr(wdt_pkg::ADDR_WD_MODE, 8'h80);
    end
    watch(2200, 1'b1, n, seen);
    chk("watchdog nmi kind", seen, 3'b010);
    // Watchdog mode 2: overflow asks for a system reset
    do_reset();
    wr(wdt_pkg::ADDR_WD_MODE, 8'h98);
    watch(2200, 1'b1, n, seen);
    chk("watchdog reset kind", seen, 3'b100);
    test_done();
  end
endmodule
